// [design/tlbt_top.sv]
// Translation buffer with test control and test data registers
module tlbt_top (
	input  wire logic                clock_in,   // Core clock
	input  wire logic                resetn_in,  // Sync reset, low
	input  wire tlbt_pkg::tlbt_req_t req_in,     // Move request
	output logic [31:0]              rdata_out,  // Read data
	output logic                     rvalid_out, // Read data valid
	output logic                     fault_out,  // Unprivileged access
	output logic                     busy_out    // Operation running
);
	localparam int NW = tlbt_pkg::NUM_WAYS;

	typedef struct packed {
		tlbt_pkg::tlbt_state_t                               st;
		logic [31:0]                                         ctrl;
		logic [31:0]                                         data;
		logic [31:0]                                         rdata;
		logic                                                rvalid;
		logic                                                fault;
		logic [tlbt_pkg::NUM_LINES-1:0][tlbt_pkg::HIST_W-1:0] hist;
	} tlbt_top_state_t;

	tlbt_top_state_t s_q;
	tlbt_top_state_t s_d;

	logic [tlbt_pkg::IDX_W-1:0]  idx;
	logic [tlbt_pkg::PAGE_W-1:0] lin;
	logic [tlbt_pkg::HIST_W-1:0] hist_now;
	tlbt_pkg::tlbt_entry_t [NW-1:0] rd_ent;
	logic [NW-1:0]                  way_we;
	tlbt_pkg::tlbt_entry_t          wr_ent;
	logic [NW-1:0]                  hit;
	logic [NW-1:0][2:0]             attr_ok;
	logic [2:0]                     wbits;
	logic                           priv;
	logic                           hit_any;
	logic [1:0]                     hit_way;
	logic [1:0]                     wr_way;

	// Tag comes from the control register as it now stands
	assign lin      = s_q.ctrl[tlbt_pkg::PAGE_MSB:tlbt_pkg::PAGE_LSB];
	assign idx      = s_q.ctrl[tlbt_pkg::IDX_MSB:tlbt_pkg::PAGE_LSB];
	assign hist_now = s_q.hist[idx];
	assign priv     = req_in.real_mode | (req_in.priv_level == tlbt_pkg::PRIV_TOP);

	// Pseudo-LRU victim: bit0 says which pair was most recent
	function automatic logic [1:0] victim(input logic [tlbt_pkg::HIST_W-1:0] h);
		logic [1:0] v;
		if (h[tlbt_pkg::HB_PAIR]) begin
			v = h[tlbt_pkg::HB_HI] ? 2'h3 : 2'h2;
		end else begin
			v = h[tlbt_pkg::HB_LO] ? 2'h1 : 2'h0;
		end
		return v;
	endfunction : victim

	function automatic logic [tlbt_pkg::HIST_W-1:0] touch(
		input logic [tlbt_pkg::HIST_W-1:0] h,
		input logic [1:0]                  w
	);
		logic [tlbt_pkg::HIST_W-1:0] r;
		r = h;
		if (w < 2'h2) begin
			r[tlbt_pkg::HB_PAIR] = 1'b1;
			r[tlbt_pkg::HB_LO]   = (w == 2'h0);
		end else begin
			r[tlbt_pkg::HB_PAIR] = 1'b0;
			r[tlbt_pkg::HB_HI]   = (w == 2'h2);
		end
		return r;
	endfunction : touch

	genvar gw;
	genvar ga;
	generate
		for (gw = 0; gw < NW; gw++) begin : g_way
			tlbt_way u_way (
				.clock_in  (clock_in),
				.resetn_in (resetn_in),
				.idx_in    (idx),
				.we_in     (way_we[gw]),
				.entry_in  (wr_ent),
				.entry_out (rd_ent[gw])
			);
			for (ga = 0; ga < 3; ga++) begin : g_attr
				localparam int LSB = (ga == 0) ? tlbt_pkg::D_LSB :
				                     (ga == 1) ? tlbt_pkg::U_LSB : tlbt_pkg::R_LSB;
				logic sbit;
				assign sbit = (ga == 0) ? rd_ent[gw].dirty :
				              (ga == 1) ? rd_ent[gw].user : rd_ent[gw].rw;
				if (gw == 0) begin : g_wr
					tlbt_attr_pair u_pair (
						.pair_in   (s_q.ctrl[LSB+1:LSB]),
						.bit_in    (sbit),
						.match_out (attr_ok[gw][ga]),
						.wbit_out  (wbits[ga])
					);
				end else begin : g_rd
					tlbt_attr_pair u_pair (
						.pair_in   (s_q.ctrl[LSB+1:LSB]),
						.bit_in    (sbit),
						.match_out (attr_ok[gw][ga]),
						.wbit_out  ()
					);
				end
			end
			// Hit needs valid entry, equal page and all attributes accepted
			assign hit[gw] = rd_ent[gw].valid & (rd_ent[gw].lin == lin) & (&attr_ok[gw]);
		end
	endgenerate

	// Lowest matching way wins if several match
	always_comb begin
		hit_any = |hit;
		hit_way = 2'h0;
		for (int w = NW - 1; w >= 0; w--) begin
			if (hit[w]) begin
				hit_way = w[1:0];
			end
		end
	end

	// Destination way for a test write
	always_comb begin
		if (s_q.data[tlbt_pkg::HIT_BIT]) begin
			wr_way = s_q.data[tlbt_pkg::SET_LSB+1:tlbt_pkg::SET_LSB];
		end else begin
			wr_way = victim(hist_now);
		end
	end

	always_comb begin
		wr_ent       = '0;
		wr_ent.valid = s_q.ctrl[tlbt_pkg::V_BIT];
		wr_ent.lin   = lin;
		wr_ent.dirty = wbits[0];
		wr_ent.user  = wbits[1];
		wr_ent.rw    = wbits[2];
		wr_ent.phys  = s_q.data[tlbt_pkg::PAGE_MSB:tlbt_pkg::PAGE_LSB];
	end

	always_comb begin
		s_d        = s_q;
		s_d.rvalid = 1'b0;
		s_d.fault  = 1'b0;
		way_we     = '0;
		case (s_q.st)
			tlbt_pkg::TLBT_IDLE: begin
				if (req_in.wr | req_in.rd) begin
					if (!priv) begin
						s_d.fault = 1'b1;
					end else if (req_in.wr) begin
						// Reserved bits are dropped, so they read back as zero
						if (req_in.sel == tlbt_pkg::SEL_CTRL) begin
							s_d.ctrl = req_in.wdata & tlbt_pkg::CTRL_WMASK;
							s_d.st   = tlbt_pkg::TLBT_EXEC;
						end else begin
							s_d.data = req_in.wdata & tlbt_pkg::DATA_WMASK;
						end
					end else begin
						s_d.rdata  = (req_in.sel == tlbt_pkg::SEL_DATA) ? s_q.data : s_q.ctrl;
						s_d.rvalid = 1'b1;
					end
				end
			end
			tlbt_pkg::TLBT_EXEC: begin
				s_d.st = tlbt_pkg::TLBT_IDLE;
				if (s_q.ctrl[tlbt_pkg::CMD_BIT]) begin
					// Lookup
					s_d.data[tlbt_pkg::HIST_LSB+tlbt_pkg::HIST_W-1:tlbt_pkg::HIST_LSB] =
						hist_now;
					s_d.data[tlbt_pkg::HIT_BIT] = hit_any;
					if (hit_any) begin
						s_d.data[tlbt_pkg::PAGE_MSB:tlbt_pkg::PAGE_LSB] = rd_ent[hit_way].phys;
						s_d.data[tlbt_pkg::SET_LSB+1:tlbt_pkg::SET_LSB] = hit_way;
						s_d.ctrl[tlbt_pkg::V_BIT] = 1'b1;
						s_d.ctrl[tlbt_pkg::D_LSB+1:tlbt_pkg::D_LSB] =
							rd_ent[hit_way].dirty ? tlbt_pkg::PAIR_ONE : tlbt_pkg::PAIR_ZERO;
						s_d.ctrl[tlbt_pkg::U_LSB+1:tlbt_pkg::U_LSB] =
							rd_ent[hit_way].user ? tlbt_pkg::PAIR_ONE : tlbt_pkg::PAIR_ZERO;
						s_d.ctrl[tlbt_pkg::R_LSB+1:tlbt_pkg::R_LSB] =
							rd_ent[hit_way].rw ? tlbt_pkg::PAIR_ONE : tlbt_pkg::PAIR_ZERO;
						s_d.hist[idx] = touch(hist_now, hit_way);
					end
				end else begin
					// Write; history bits in the data register are ignored
					way_we[wr_way] = 1'b1;
					s_d.hist[idx]  = touch(hist_now, wr_way);
				end
			end
			default: begin
				s_d.st = tlbt_pkg::TLBT_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign rdata_out  = s_q.rdata;
	assign rvalid_out = s_q.rvalid;
	assign fault_out  = s_q.fault;
	assign busy_out   = (s_q.st == tlbt_pkg::TLBT_EXEC);
endmodule : tlbt_top

// [inc/tlbt_pkg.sv]
// Shared constants and types for the translation buffer test access block
// Summary of operation
// - Only privileged moves or real mode reach registers
// - Thirty-two entries, four ways, eight lines
// - Entry holds 24-bit tag, 20-bit data
// - Tag: linear page, valid, three attributes
// - Data holds physical page of linear page
// - Control register forms tag for every operation
// - Test write stores data register page
// - Test lookup loads entry data into data register
// - Data bits 31:12 carry the physical page
// - Lookup reports prior history bits; write ignores
// - Lookup hit sets hit flag bit 4
// - Write with hit flag uses set field
// - Set field bits 3:2 pick written way
// - Lookup hit reports matching way in set field
// - Linear page searched; hit updates other fields
// - Write: valid bit 11 validates or invalidates
// - Attribute pairs match and write as true/complement
// - Command bit 0: one lookup, zero write
package tlbt_pkg;
	localparam int NUM_WAYS   = 4;
	localparam int NUM_LINES  = 8;
	localparam int IDX_W      = 3;
	localparam int PAGE_W     = 20;
	localparam int HIST_W     = 3;
	localparam int PAGE_LSB   = 12;
	localparam int PAGE_MSB   = 31;
	localparam int IDX_MSB    = 14;
	localparam int V_BIT      = 11;
	localparam int D_LSB      = 9;
	localparam int U_LSB      = 7;
	localparam int R_LSB      = 5;
	localparam int CMD_BIT    = 0;
	localparam int HIST_LSB   = 7;
	localparam int HIT_BIT    = 4;
	localparam int SET_LSB    = 2;
	localparam logic [31:0] CTRL_WMASK = 32'hffff_ffe1;
	localparam logic [31:0] DATA_WMASK = 32'hffff_f39c;
	localparam logic        SEL_CTRL   = 1'b0;
	localparam logic        SEL_DATA   = 1'b1;
	localparam logic [1:0]  PAIR_ONE   = 2'h2;
	localparam logic [1:0]  PAIR_ZERO  = 2'h1;
	localparam logic [1:0]  PRIV_TOP   = 2'h0;
	localparam int HB_PAIR    = 0;
	localparam int HB_LO      = 1;
	localparam int HB_HI      = 2;

	typedef enum logic {
		TLBT_IDLE,
		TLBT_EXEC
	} tlbt_state_t;

	typedef struct packed {
		logic              valid;
		logic [PAGE_W-1:0] lin;
		logic              dirty;
		logic              user;
		logic              rw;
		logic [PAGE_W-1:0] phys;
	} tlbt_entry_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic        sel;
		logic [1:0]  priv_level;
		logic        real_mode;
		logic [31:0] wdata;
	} tlbt_req_t;
endpackage : tlbt_pkg

// [design/tlbt_attr_pair.sv]
// Attribute true/complement pair: lookup match and write value
module tlbt_attr_pair (
	input  wire logic [1:0] pair_in,   // Pair from control register
	input  wire logic       bit_in,    // Stored attribute bit
	output logic            match_out, // Pair accepts stored bit
	output logic            wbit_out   // Bit to store on write
);
	always_comb begin
		match_out = (pair_in[1] & bit_in) | (pair_in[0] & ~bit_in);
		wbit_out  = (pair_in == tlbt_pkg::PAIR_ONE);
	end
endmodule : tlbt_attr_pair

// [design/tlbt_way.sv]
// One way of the translation buffer: eight entries in flip-flops
module tlbt_way (
	input  wire logic                      clock_in,    // Core clock
	input  wire logic                      resetn_in,   // Sync reset, low
	input  wire logic [tlbt_pkg::IDX_W-1:0] idx_in,      // Line index
	input  wire logic                      we_in,       // Write entry
	input  wire tlbt_pkg::tlbt_entry_t     entry_in,    // Entry to write
	output tlbt_pkg::tlbt_entry_t          entry_out    // Entry at index
);
	typedef struct packed {
		tlbt_pkg::tlbt_entry_t [tlbt_pkg::NUM_LINES-1:0] ent;
	} tlbt_way_state_t;

	tlbt_way_state_t s_q;
	tlbt_way_state_t s_d;

	always_comb begin
		s_d = s_q;
		if (we_in) begin
			s_d.ent[idx_in] = entry_in;
		end
	end

	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign entry_out = s_q.ent[idx_in];
endmodule : tlbt_way

// [bench/tlbt_top_sva.sv]
// Port assertions for the translation buffer test block
module tlbt_top_sva (
	input wire logic                clock_in,   // Clock
	input wire logic                resetn_in,  // Reset, low
	input wire tlbt_pkg::tlbt_req_t req_in,     // Move request
	input wire logic [31:0]         rdata_out,  // Read data
	input wire logic                rvalid_out, // Read valid
	input wire logic                fault_out,  // Refusal
	input wire logic                busy_out    // Busy
);
	timeunit 1ns;
	timeprecision 1ps;
	logic priv;
	logic take;
	assign priv = req_in.real_mode || (req_in.priv_level == tlbt_pkg::PRIV_TOP);
	assign take = (req_in.wr || req_in.rd) && !busy_out;
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!resetn_in);
	sequence s_op_start;
		take && priv && req_in.wr && (req_in.sel == tlbt_pkg::SEL_CTRL);
	endsequence
	sequence s_busy_once;
		busy_out ##1 !busy_out;
	endsequence
	a_read_answer: assert property (take && priv && !req_in.wr |=> rvalid_out && !fault_out)
		else $error("read not answered");
	a_fault_pulse: assert property (take && !priv |=> fault_out && !rvalid_out && !busy_out)
		else $error("unprivileged move not refused");
	a_op_busy: assert property (s_op_start |=> s_busy_once)
		else $error("busy not one cycle");
	a_busy_cause: assert property ($rose(busy_out) |-> $past(req_in.wr && priv))
		else $error("busy without control write");
	a_busy_refuse: assert property (busy_out |=> !rvalid_out && !fault_out)
		else $error("move taken while busy");
	a_rdata_hold: assert property (!rvalid_out |-> $stable(rdata_out))
		else $error("read data moved");
	a_data_resv: assert property (rvalid_out && $past(req_in.sel) |->
		(rdata_out & 32'h0000_0c63) == 32'h0) else $error("reserved data bits set");
	a_rvalid_cause: assert property (rvalid_out |->
		$past(req_in.rd && !req_in.wr && !busy_out && priv)) else $error("stray read valid");
endmodule : tlbt_top_sva

bind tlbt_top tlbt_top_sva chk_u (.clock_in(clock_in), .resetn_in(resetn_in), .req_in(req_in),
	.rdata_out(rdata_out), .rvalid_out(rvalid_out), .fault_out(fault_out), .busy_out(busy_out));

// [bench/tlbt_core_model.sv]
// Processor core model issuing test register moves
module tlbt_core_model (
	input  wire logic           clock_in, // Core clock
	output tlbt_pkg::tlbt_req_t req_out   // Move request
);
	timeunit 1ns;
	timeprecision 1ps;
	initial req_out = '0;
	task automatic mov(input logic w, s, input logic [1:0] pl, input logic rm,
		input logic [31:0] d);
		@(negedge clock_in);
		req_out.wr = w;
		req_out.rd = !w;
		req_out.sel = s;
		req_out.priv_level = pl;
		req_out.real_mode = rm;
		req_out.wdata = d;
	endtask : mov
	// Released data lines are scrambled, not held
	task automatic idle();
		@(negedge clock_in);
		req_out.wr = 1'b0;
		req_out.rd = 1'b0;
		req_out.wdata = ~req_out.wdata;
	endtask : idle
endmodule : tlbt_core_model

// [bench/tlbt_top_tb.sv]
// Self-checking bench for the translation buffer test block
module tlbt_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic                clock_in, resetn_in, rvalid_out, fault_out, busy_out;
	logic [31:0]         rdata_out;
	tlbt_pkg::tlbt_req_t req;
	int                  n_fail, checks_done;
	logic [32:0]         exp_q[$];
	logic [31:0]         msk_q[$];
	logic [19:0]         la[6];
	logic [19:0]         pg;
	tlbt_top dut_u (.clock_in(clock_in), .resetn_in(resetn_in), .req_in(req),
		.rdata_out(rdata_out), .rvalid_out(rvalid_out), .fault_out(fault_out), .busy_out(busy_out));
	tlbt_core_model core_u (.clock_in(clock_in), .req_out(req));
	initial begin
		clock_in = 1'b0;
		forever #2 clock_in = ~clock_in;
	end
	task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic close_out();
		$display("Checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : close_out
	// One move; any answer expected from it is noted for the watcher
	task automatic acc(input logic w, s, input logic [1:0] pl, input logic rm,
		input logic [31:0] d, e, mk);
		logic f;
		f = !(rm || pl == tlbt_pkg::PRIV_TOP);
		if (f || !w) begin
			exp_q.push_back({f, e & mk & {32{!f}}});
			msk_q.push_back(mk & {32{!f}});
		end
		core_u.mov(w, s, pl, rm, d);
		core_u.idle();
		for (int i = 0; i < 20 && exp_q.size() > 0; i++) @(negedge clock_in);
		if (exp_q.size() > 0) begin
			n_fail++;
			close_out();
		end
	endtask : acc
	task automatic wrt(input logic s, input logic [31:0] d);
		acc(1'b1, s, 2'h0, 1'b0, d, 32'h0, 32'h0);
	endtask : wrt
	task automatic rdd(input logic s, input logic [31:0] e, mk);
		acc(1'b0, s, 2'h0, 1'b0, 32'h0, e, mk);
	endtask : rdd
	always @(negedge clock_in) begin
		if (resetn_in && (rvalid_out === 1'b1 || fault_out === 1'b1)) begin
			if (exp_q.size() == 0) begin
				check("stray", 33'h1, 33'h0);
			end else begin
				check("ans", {fault_out, rdata_out & msk_q.pop_front()}, exp_q.pop_front());
			end
		end
	end
	initial begin
		resetn_in = 1'b0;
		n_fail = 0;
		checks_done = 0;
		void'($urandom(32'h75928fc0));
		repeat (10) @(negedge clock_in);
		resetn_in = 1'b1;
		rdd(1'b1, 32'h0, '1);
		acc(1'b1, 1'b0, 2'h3, 1'b0, 32'h0000_1001, 32'h0, 32'h0);
		acc(1'b0, 1'b1, 2'h1, 1'b0, 32'h0, 32'h0, 32'h0);
		acc(1'b0, 1'b0, 2'h3, 1'b1, 32'h0, 32'h0, '1);
		wrt(1'b1, '1);
		rdd(1'b1, ~32'h0000_0c63, '1);
		// Each way by set field, then looked up on a fresh line
		for (int w = 0; w < 4; w++) begin
			pg = 20'($urandom);
			la[w] = {17'($urandom), 3'(w)};
			wrt(1'b1, {pg, 7'h0, 1'b1, 2'(w), 2'h0});
			wrt(1'b0, {la[w], 1'b1, 6'h26, 5'h0});
			wrt(1'b0, {la[w], 7'h3f, 5'h1});
			rdd(1'b1, {pg, 2'h0, w == 2, w == 0, w < 2, 2'h0, 1'b1, 2'(w), 2'h0}, '1);
			rdd(1'b0, {la[w], 12'hcc1}, '1);
		end
		// Dirty pair codes against a stored one
		for (int c = 0; c < 4; c++) begin
			wrt(1'b0, {la[0], 1'b0, 2'(c), 4'hf, 5'h1});
			rdd(1'b1, {27'h0, c[1], 4'h0}, 32'h10);
		end
		wrt(1'b1, 32'h10);
		wrt(1'b0, {la[0], 1'b0, 6'h26, 5'h0});
		wrt(1'b0, {la[0], 7'h3f, 5'h1});
		rdd(1'b1, 32'h0, 32'h10);
		// Hit flag clear: ways 0 then 2 chosen by the pointer
		for (int k = 0; k < 2; k++) begin
			la[4 + k] = {17'($urandom), 3'h5};
			wrt(1'b1, 32'h0000_000c);
			wrt(1'b0, {la[4 + k], 1'b1, 6'h26, 5'h0});
			wrt(1'b0, {la[4 + k], 7'h3f, 5'h1});
			rdd(1'b1, {27'h0, 1'b1, k[0], 3'h0}, 32'h1c);
		end
		// A read in the busy cycle is ignored
		core_u.mov(1'b1, 1'b0, 2'h0, 1'b0, {la[5], 7'h3f, 5'h1});
		core_u.mov(1'b0, 1'b1, 2'h0, 1'b0, 32'h0);
		check("busy", 33'(busy_out), 33'h1);
		core_u.idle();
		check("idle", 33'(busy_out), 33'h0);
		rdd(1'b1, 32'h18, 32'h1c);
		close_out();
	end
endmodule : tlbt_top_tb
